// ==== include/umls_cfg.svh ====
// Purpose: offsets, field positions, reset values and counts for the modem control / line status block
// Assumes: word-indexed register port, 8-bit data
// Notes: definitions only
`ifndef UMLS_CFG_SVH
`define UMLS_CFG_SVH
// register addresses on the plain register port
`define UMLS_ADDR_W 3
`define UMLS_OFF_HOLD 3'h0
`define UMLS_OFF_MODEM 3'h4
`define UMLS_OFF_LSTAT 3'h5
`define UMLS_OFF_CFG 3'h2
`define UMLS_OFF_IST 3'h6
`define UMLS_OFF_IMK 3'h7
// modem control fields
`define UMLS_MC_DTR 0
`define UMLS_MC_RTS 1
`define UMLS_MC_AUTO 5
`define UMLS_MC_RST 8'h00
`define UMLS_MC_MASK 8'h23
// line status fields
`define UMLS_LS_ERR 7
`define UMLS_LS_TEMT 6
`define UMLS_LS_THRE 5
// config register fields
`define UMLS_CF_FIFO 0
`define UMLS_CF_TRIG_LO 4
`define UMLS_CF_TRIG_HI 7
`define UMLS_CF_RST 8'h80
// interrupt status fields
`define UMLS_IS_THRE 0
`define UMLS_IS_ERR 1
`define UMLS_IS_W 2
// transmit fifo depth and character time
`define UMLS_TXF_DEPTH 64
`define UMLS_CNT_W 7
`define UMLS_CHAR_NS 1000
`define UMLS_CLK_NS 10
`define UMLS_CHAR_CYC ((`UMLS_CHAR_NS + `UMLS_CLK_NS - 1) / `UMLS_CLK_NS)
`endif

// ==== include/umls_pkg.sv ====
// Purpose: types shared by the modem control / line status block
// Assumes: nothing beyond the cfg header
// Notes: flow modes and shifter states
package umls_pkg;
	typedef enum logic [1:0] {
		umls_flow_off,
		umls_flow_cts,
		umls_flow_rts_cts
	} umls_flow_t;
	typedef enum logic [1:0] {
		umls_sh_idle,
		umls_sh_busy
	} umls_shst_t;
endpackage : umls_pkg

// ==== design/umls_sync.sv ====
// Purpose: two-flop synchroniser for a pin level
// Assumes: single clock ref_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module umls_sync (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic pin_in,
	output logic pin_sync
);
	logic meta_q;
	// reset to 1 since the modem pins idle high
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			meta_q <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule : umls_sync

// ==== design/umls_txq.sv ====
// Purpose: transmit holding store, a single register or a 64-entry fifo
// Assumes: push and pop never in the same cycle from an empty queue
// Notes: in single mode depth is one
`timescale 1ns/1ps
`include "umls_cfg.svh"
module umls_txq (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic fifo_mode,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	output logic [7:0] pop_data,
	output logic empty,
	output logic full
);
	logic [7:0] mem [0:`UMLS_TXF_DEPTH-1];
	logic [5:0] wr_q;
	logic [5:0] rd_q;
	logic [`UMLS_CNT_W-1:0] cnt_q;
	wire logic do_push;
	wire logic do_pop;
	// single mode: one slot; a push onto a full slot overwrites
	assign empty = (cnt_q == 7'h00);
	assign full = fifo_mode ? (cnt_q == 7'h40) : (cnt_q == 7'h01);
	assign do_push = push && (!full || !fifo_mode);
	assign do_pop = pop && !empty;
	assign pop_data = mem[rd_q];
	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[wr_q] <= push_data;
		end
	end
	// pointers and count; pointers move only in fifo mode, single mode holds both where they stand
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_q <= 6'h00;
			rd_q <= 6'h00;
			cnt_q <= 7'h00;
		end else begin
			if (do_push && fifo_mode) begin
				wr_q <= wr_q + 6'h01;
			end
			if (do_pop && fifo_mode) begin
				rd_q <= rd_q + 6'h01;
			end
			if (!fifo_mode && do_push) begin
				cnt_q <= 7'h01;
			end else if (do_push && !do_pop) begin
				cnt_q <= cnt_q + 7'h01;
			end else if (do_pop && !do_push) begin
				cnt_q <= cnt_q - 7'h01;
			end
		end
	end
endmodule : umls_txq

// ==== design/umls_top.sv ====
// Purpose: modem control outputs, auto flow control and upper line status flags of a uart
// Assumes: receive path reports its error-present flag and fill level on same-clock ports
// Notes: the shift register is modelled by a character timer, not a serialiser
//
// Summary of operation
// RL1: rts force bit 0 drives rts_n high; 1 drives it low.
// RL2: dtr force bit 0 drives dtr_n high; 1 drives it low.
// RL3: auto flow enable and rts force both set: auto rts and auto cts.
// RL4: auto flow enable set, rts force clear: auto cts only, manual rts.
// RL5: auto flow enable clear: no automatic rts or cts.
// RL6: fifo data error flag set while any errored character sits in receive fifo; a line status read still clears it for one cycle.
// RL7: reading line status clears the fifo data error flag.
// RL8: non-fifo: transmitter empty when holding and shift register both empty.
// RL9: fifo mode: transmitter empty only when tx fifo and shifter empty.
// RL10: non-fifo: holding empty sets when character moves into shift register.
// RL11: non-fifo: holding empty clears with the cpu write to holding register.
// RL12: interrupt while holding empty and its enable are both set; code uses a sticky status bit, cleared only by a write to it.
// RL13: fifo mode: holding empty sets on empty fifo, clears on a write.
// RL14: auto flow control enabled by the auto flow enable bit.
// RL15: auto cts finishes current character, then holds while cts deasserted.
// RL16: auto rts drops rts at receive trigger level, restores below it.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "umls_cfg.svh"
module umls_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [`UMLS_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic cts_n,
	input wire logic [6:0] rx_level,
	input wire logic rx_err_present,
	output logic rts_n,
	output logic dtr_n,
	output logic tx_start,
	output logic [7:0] tx_char,
	output logic irq
);
	logic [7:0] modem_ctrl_q;
	logic [7:0] cfg_q;
	logic [`UMLS_IS_W-1:0] ist_q;
	logic [`UMLS_IS_W-1:0] ist_d;
	logic [`UMLS_IS_W-1:0] imk_q;
	wire logic [`UMLS_IS_W-1:0] imk_d;
	logic err_q;
	logic thre_q;
	logic thre_d;
	logic rts_auto_q;
	logic [7:0] rdata_d;
	logic [15:0] char_cnt_q;
	umls_pkg::umls_shst_t sh_q;
	wire logic cts_n_s;
	wire logic [7:0] q_data;
	wire logic q_empty;
	wire logic fifo_mode;
	wire logic auto_flow_enable;
	wire logic rts_bit;
	wire logic dtr_bit;
	umls_pkg::umls_flow_t flow_mode;
	wire logic auto_cts;
	wire logic auto_rts;
	wire logic [3:0] rx_trig;
	wire logic wr_hold;
	wire logic wr_modem;
	wire logic wr_cfg;
	wire logic wr_ist;
	wire logic wr_imk;
	wire logic rd_status;
	wire logic sh_free;
	wire logic load_sh;
	wire logic temt;
	wire logic rts_drive;
	wire logic thre_rise;
	wire logic err_rise;

	// cts pin crosses into the clock domain first
	umls_sync u_cts_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin_in(cts_n),
		.pin_sync(cts_n_s)
	);

	// address decode
	assign wr_hold = reg_wr && (reg_addr == `UMLS_OFF_HOLD);
	assign wr_modem = reg_wr && (reg_addr == `UMLS_OFF_MODEM);
	assign wr_cfg = reg_wr && (reg_addr == `UMLS_OFF_CFG);
	assign wr_ist = reg_wr && (reg_addr == `UMLS_OFF_IST);
	assign wr_imk = reg_wr && (reg_addr == `UMLS_OFF_IMK);
	assign rd_status = reg_rd && (reg_addr == `UMLS_OFF_LSTAT);
	// mask as it will stand next cycle, so irq tracks status and mask without lag
	assign imk_d = wr_imk ? reg_wdata[`UMLS_IS_W-1:0] : imk_q;

	// configuration fields
	assign fifo_mode = cfg_q[`UMLS_CF_FIFO];
	assign rx_trig = cfg_q[`UMLS_CF_TRIG_HI:`UMLS_CF_TRIG_LO];
	assign auto_flow_enable = modem_ctrl_q[`UMLS_MC_AUTO]; // [RL14]
	assign rts_bit = modem_ctrl_q[`UMLS_MC_RTS];
	assign dtr_bit = modem_ctrl_q[`UMLS_MC_DTR];

	// flow mode table: auto flow enable selects, rts force picks auto rts
	always_comb begin
		case ({auto_flow_enable, rts_bit})
			2'b11: flow_mode = umls_pkg::umls_flow_rts_cts; // [RL3]
			2'b10: flow_mode = umls_pkg::umls_flow_cts; // [RL4]
			default: flow_mode = umls_pkg::umls_flow_off; // [RL5]
		endcase
	end
	assign auto_cts = (flow_mode != umls_pkg::umls_flow_off); // [RL3] [RL4]
	assign auto_rts = (flow_mode == umls_pkg::umls_flow_rts_cts); // [RL3]

	// rts pin: manual follows the force bit, auto also gated by rx level
	assign rts_drive = rts_bit && (!auto_rts || rts_auto_q); // [RL1] [RL16]

	// holding store
	umls_txq u_txq (
		.ref_clk(ref_clk),
		.rst(rst),
		.fifo_mode(fifo_mode),
		.push(wr_hold),
		.push_data(reg_wdata),
		.pop(load_sh),
		.pop_data(q_data),
		.empty(q_empty),
		.full()
	);

	// a new character only starts between characters, so cts never cuts one short
	assign sh_free = (sh_q == umls_pkg::umls_sh_idle);
	assign load_sh = sh_free && !q_empty && !(auto_cts && cts_n_s); // [RL15]
	assign temt = q_empty && sh_free; // [RL8] [RL9]

	// holding empty: set on transfer or empty fifo, cleared by the loading write
	always_comb begin
		thre_d = thre_q;
		if (fifo_mode) begin
			if (wr_hold) begin
				thre_d = 1'b0; // [RL13]
			end else if (q_empty) begin
				thre_d = 1'b1; // [RL13]
			end else if (load_sh) begin
				thre_d = 1'b0;
			end
		end else begin
			if (wr_hold) begin
				thre_d = 1'b0; // [RL11]
			end else if (load_sh) begin
				thre_d = 1'b1; // [RL10]
			end
		end
	end

	// edges that feed sticky interrupt status
	assign thre_rise = thre_d && !thre_q;
	assign err_rise = rx_err_present && !err_q;

	// sticky status: a set in the clearing cycle wins
	always_comb begin
		ist_d = ist_q;
		if (wr_ist) begin
			ist_d = ist_q & ~reg_wdata[`UMLS_IS_W-1:0];
		end
		if (thre_rise) begin
			ist_d[`UMLS_IS_THRE] = 1'b1; // [RL12]
		end
		if (err_rise) begin
			ist_d[`UMLS_IS_ERR] = 1'b1;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr)
			`UMLS_OFF_MODEM: rdata_d = modem_ctrl_q & `UMLS_MC_MASK;
			`UMLS_OFF_LSTAT: begin
				rdata_d[`UMLS_LS_ERR] = err_q;
				rdata_d[`UMLS_LS_TEMT] = temt;
				rdata_d[`UMLS_LS_THRE] = thre_q;
			end
			`UMLS_OFF_CFG: rdata_d = cfg_q;
			`UMLS_OFF_IST: rdata_d = {6'h00, ist_q};
			`UMLS_OFF_IMK: rdata_d = {6'h00, imk_q};
			default: rdata_d = 8'h00;
		endcase
	end

	// software registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			modem_ctrl_q <= `UMLS_MC_RST;
			cfg_q <= `UMLS_CF_RST;
			imk_q <= 2'h0;
			ist_q <= 2'h0;
		end else begin
			if (wr_modem) begin
				modem_ctrl_q <= reg_wdata & `UMLS_MC_MASK;
			end
			if (wr_cfg) begin
				cfg_q <= reg_wdata;
			end
			if (wr_imk) begin
				imk_q <= reg_wdata[`UMLS_IS_W-1:0];
			end
			ist_q <= ist_d;
		end
	end

	// fifo data error: the clearing read wins while the flag is set; an error still present sets it again next cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_q <= 1'b0;
		end else if (rx_err_present && !err_q) begin
			err_q <= 1'b1; // [RL6]
		end else if (rd_status) begin
			err_q <= 1'b0; // [RL7]
		end
	end

	// holding empty and auto rts single-threshold compare against the receive trigger level
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			thre_q <= 1'b1;
			rts_auto_q <= 1'b1;
		end else begin
			thre_q <= thre_d;
			if (rx_level >= {3'h0, rx_trig}) begin
				rts_auto_q <= 1'b0; // [RL16]
			end else begin
				rts_auto_q <= 1'b1; // [RL16]
			end
		end
	end

	// character timer stands in for the shift register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sh_q <= umls_pkg::umls_sh_idle;
			char_cnt_q <= 16'h0000;
		end else begin
			case (sh_q)
				umls_pkg::umls_sh_idle: begin
					if (load_sh) begin
						sh_q <= umls_pkg::umls_sh_busy;
						char_cnt_q <= 16'((`UMLS_CHAR_CYC) - 1);
					end
				end
				umls_pkg::umls_sh_busy: begin
					if (char_cnt_q == 16'h0000) begin
						sh_q <= umls_pkg::umls_sh_idle;
					end else begin
						char_cnt_q <= char_cnt_q - 16'h0001;
					end
				end
				default: sh_q <= umls_pkg::umls_sh_idle;
			endcase
		end
	end

	// registered outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
			tx_start <= 1'b0;
			tx_char <= 8'h00;
			irq <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			rts_n <= !rts_drive; // [RL1]
			dtr_n <= !dtr_bit; // [RL2]
			tx_start <= load_sh;
			if (load_sh) begin
				tx_char <= q_data;
			end
			irq <= |(ist_d & imk_d); // [RL12]
			reg_rdata <= reg_rd ? rdata_d : 8'h00;
		end
	end

	// assertions
	property p_rts_manual;
		@(posedge ref_clk) disable iff (rst)
		!auto_rts |=> (rts_n == !$past(rts_bit));
	endproperty
	a_rts_manual: assert property (p_rts_manual) else $error("rts_n does not follow force bit"); // [RL1]

	property p_dtr;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> (dtr_n == !$past(dtr_bit));
	endproperty
	a_dtr: assert property (p_dtr) else $error("dtr_n does not follow force bit"); // [RL2]

	property p_auto_both;
		@(posedge ref_clk) disable iff (rst)
		(auto_flow_enable && rts_bit) |-> (auto_rts && auto_cts);
	endproperty
	a_auto_both: assert property (p_auto_both) else $error("auto rts and cts not both on"); // [RL3]

	property p_auto_cts_only;
		@(posedge ref_clk) disable iff (rst)
		(auto_flow_enable && !rts_bit) |-> (auto_cts && !auto_rts);
	endproperty
	a_auto_cts_only: assert property (p_auto_cts_only) else $error("auto cts only mode wrong"); // [RL4]

	property p_auto_off;
		@(posedge ref_clk) disable iff (rst)
		!auto_flow_enable |-> (!auto_cts && !auto_rts && (load_sh == (sh_free && !q_empty)));
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("auto flow active with enable clear"); // [RL5]

	property p_err_set;
		@(posedge ref_clk) disable iff (rst)
		(rx_err_present && !err_q) |=> err_q;
	endproperty
	a_err_set: assert property (p_err_set) else $error("data error flag missed"); // [RL6]

	property p_err_clear;
		@(posedge ref_clk) disable iff (rst)
		(rd_status && err_q && !rx_err_present) |=> !err_q;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("data error flag not cleared by read"); // [RL7]

	property p_thre_clear;
		@(posedge ref_clk) disable iff (rst)
		wr_hold |=> !thre_q;
	endproperty
	a_thre_clear: assert property (p_thre_clear) else $error("holding empty not cleared by write"); // [RL11]

	property p_thre_set;
		@(posedge ref_clk) disable iff (rst)
		(!fifo_mode && load_sh && !wr_hold) |=> thre_q;
	endproperty
	a_thre_set: assert property (p_thre_set) else $error("holding empty not set on transfer"); // [RL10]

	property p_cts_hold;
		@(posedge ref_clk) disable iff (rst)
		(auto_cts && cts_n_s) |-> !load_sh;
	endproperty
	a_cts_hold: assert property (p_cts_hold) else $error("character started while cts deasserted"); // [RL15]

	property p_irq;
		@(posedge ref_clk) disable iff (rst)
		(ist_q[`UMLS_IS_THRE] && imk_q[`UMLS_IS_THRE]) |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing for holding empty"); // [RL12]
endmodule : umls_top

// ==== tb/umls_peer.sv ====
// Purpose: modem peer model driving clear-to-send and the receive-side status of the block
// Assumes: the bench sets targets; the peer moves towards them on its own pace
// Notes: cts follows a hold request only after a settable lag, so a slow far end can be shown
`timescale 1ns/1ps
module umls_peer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hold_req,
	input wire logic [3:0] lag,
	input wire logic [6:0] fill_req,
	input wire logic err_req,
	output logic cts_n,
	output logic [6:0] rx_level,
	output logic rx_err_present
);
	logic [3:0] wait_q;
	// cts flips only after the lag runs out; fill steps one a cycle, as a real receive fifo would
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cts_n <= 1'b0;
			wait_q <= 4'h0;
			rx_level <= 7'h00;
			rx_err_present <= 1'b0;
		end else begin
			wait_q <= (hold_req != cts_n) ? wait_q + 4'h1 : 4'h0;
			if (hold_req != cts_n && wait_q >= lag) begin
				cts_n <= hold_req;
			end
			if (rx_level < fill_req) begin
				rx_level <= rx_level + 7'h01;
			end else if (rx_level > fill_req) begin
				rx_level <= rx_level - 7'h01;
			end
			rx_err_present <= err_req;
		end
	end
endmodule : umls_peer

// ==== tb/umls_top_tb.sv ====
// Purpose: self-checking bench for modem control pins, flow modes and upper line status flags
// Assumes: one clock, reads answered one cycle later, a character takes 100 cycles
// Notes: reads and sent characters are noted in queues and compared when they appear
`timescale 1ns/1ps
`include "umls_cfg.svh"
module umls_top_tb;
	logic ref_clk, rst, reg_wr, reg_rd, cts_n, rx_err_present, rts_n, dtr_n, tx_start, irq;
	logic hold_req, err_req, rd_p;
	logic [2:0] reg_addr;
	logic [3:0] lag;
	logic [6:0] rx_level, fill_req;
	logic [7:0] reg_wdata, reg_rdata, tx_char, c;
	logic [7:0] rd_q[$];
	logic [7:0] tx_q[$];
	logic [31:0] seed;
	int fails, total_checks, i;

	umls_top i_umls_top (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cts_n(cts_n), .rx_level(rx_level),
		.rx_err_present(rx_err_present), .rts_n(rts_n), .dtr_n(dtr_n), .tx_start(tx_start),
		.tx_char(tx_char), .irq(irq));
	umls_peer i_umls_peer (.ref_clk(ref_clk), .rst(rst), .hold_req(hold_req), .lag(lag),
		.fill_req(fill_req), .err_req(err_req), .cts_n(cts_n), .rx_level(rx_level),
		.rx_err_present(rx_err_present));

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	// 32-bit galois shift register, one step per call
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h8020_0003 : 32'h0000_0000);
	endfunction : lfsr_next
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	// one-cycle strobes, changed just after an edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		rd_q.push_back(exp);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd
	// random characters go to the holding store and are noted as expected on the line
	task automatic send();
		seed = lfsr_next(seed);
		c = seed[7:0];
		tx_q.push_back(c);
		wr(`UMLS_OFF_HOLD, c);
	endtask : send
	task automatic pins(input logic e_rts, input logic e_dtr);
		cyc(3);
		check("rts_n", {7'h00, rts_n}, {7'h00, e_rts});
		check("dtr_n", {7'h00, dtr_n}, {7'h00, e_dtr});
	endtask : pins

	// clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// the whole run needs about 1100 cycles, so this only trips on a hang
	initial begin
		#200000;
		fails++;
		print_verdict();
	end
	// watcher: read data stand only in the cycle after the strobe, so look exactly there
	always @(posedge ref_clk) begin
		if (rd_p === 1'b1) check("reg_rdata", reg_rdata, rd_q.pop_front());
		if (tx_start === 1'b1 && tx_q.size() == 0) check("tx_start", 8'h01, 8'h00);
		else if (tx_start === 1'b1) check("tx_char", tx_char, tx_q.pop_front());
		rd_p = reg_rd;
	end

	initial begin
		{rst, reg_wr, reg_rd, hold_req, err_req, rd_p} = 6'b100000;
		{reg_addr, reg_wdata, fill_req, lag} = 22'h0;
		seed = 32'h0000_f22f;
		cyc(2);
		rst <= 1'b0;
		pins(1'b1, 1'b1);
		rd(`UMLS_OFF_MODEM, 8'h00);
		rd(`UMLS_OFF_LSTAT, 8'h60);
		rd(`UMLS_OFF_CFG, `UMLS_CF_RST);
		rd(3'h1, 8'h00);
		rd(3'h3, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(`UMLS_OFF_MODEM, i[7:0]);
			pins(~i[1], ~i[0]);
		end
		wr(`UMLS_OFF_MODEM, 8'hdc);
		rd(`UMLS_OFF_MODEM, 8'h00);
		// single mode: second character waits in the holding register
		wr(`UMLS_OFF_IMK, 8'h01);
		send();
		send();
		cyc(3);
		rd(`UMLS_OFF_LSTAT, 8'h00);
		cyc(110);
		rd(`UMLS_OFF_LSTAT, 8'h20);
		check("irq", {7'h00, irq}, 8'h01);
		wr(`UMLS_OFF_IMK, 8'h00);
		cyc(2);
		check("irq", {7'h00, irq}, 8'h00);
		wr(`UMLS_OFF_IMK, 8'h01);
		cyc(2);
		check("irq", {7'h00, irq}, 8'h01);
		wr(`UMLS_OFF_IST, 8'h01);
		cyc(2);
		check("irq", {7'h00, irq}, 8'h00);
		cyc(110);
		rd(`UMLS_OFF_LSTAT, 8'h60);
		// fifo mode: three characters queued
		wr(`UMLS_OFF_CFG, 8'h81);
		for (i = 0; i < 3; i++) send();
		cyc(3);
		rd(`UMLS_OFF_LSTAT, 8'h00);
		cyc(200);
		rd(`UMLS_OFF_LSTAT, 8'h20);
		cyc(120);
		rd(`UMLS_OFF_LSTAT, 8'h60);
		// auto cts only: rts stays manual, a slow far end holds the transmitter
		lag <= 4'h7;
		fill_req <= 7'h08;
		hold_req <= 1'b1;
		wr(`UMLS_OFF_MODEM, 8'h20);
		pins(1'b1, 1'b1);
		// the lag plus the pin synchroniser must run out before the character is offered
		cyc(10);
		send();
		cyc(150);
		rd(`UMLS_OFF_LSTAT, 8'h00);
		hold_req <= 1'b0;
		cyc(130);
		rd(`UMLS_OFF_LSTAT, 8'h60);
		// auto rts: trigger is 8, check both sides of the boundary
		wr(`UMLS_OFF_MODEM, 8'h22);
		cyc(5);
		pins(1'b1, 1'b1);
		fill_req <= 7'h07;
		cyc(5);
		pins(1'b0, 1'b1);
		// flow off: rts follows the force bit, cts is ignored
		fill_req <= 7'h0a;
		hold_req <= 1'b1;
		wr(`UMLS_OFF_MODEM, 8'h02);
		cyc(20);
		pins(1'b0, 1'b1);
		send();
		cyc(130);
		rd(`UMLS_OFF_LSTAT, 8'h60);
		// receive error shows in the flag until a read
		wr(`UMLS_OFF_IST, 8'h03);
		err_req <= 1'b1;
		cyc(5);
		err_req <= 1'b0;
		cyc(5);
		rd(`UMLS_OFF_IST, 8'h02);
		rd(`UMLS_OFF_LSTAT, 8'he0);
		rd(`UMLS_OFF_LSTAT, 8'h60);
		cyc(3);
		print_verdict();
	end
endmodule : umls_top_tb
